/* hdl/octd_pkg.sv */
// Constants, field layouts and carrier types of the octal converter serial decoder
package octd_pkg;

    // Serial word layout
    localparam int WORD_BITS   = 16;
    localparam int CNT_W       = 5;
    localparam int BIT_DC      = 15;
    localparam int BIT_MODE_HI = 14;
    localparam int BIT_MODE_LO = 13;
    localparam int BIT_CH_HI   = 14;
    localparam int BIT_CH_LO   = 12;
    localparam int BIT_DATA_HI = 11;
    localparam int BIT_RST_ALL = 12;
    localparam int BIT_REF_HI  = 5;
    localparam int BIT_LOAD_HI = 1;
    localparam int BIT_PD_HI   = 7;
    localparam int NUM_CH      = 8;
    localparam int CH_W        = 3;

    localparam logic [CNT_W-1:0] FULL_COUNT = 5'h10;

    // Control modes carried in the two mode bits
    typedef enum logic [1:0] {
        MODE_REFGAIN = 2'h0,
        MODE_LOAD    = 2'h1,
        MODE_PWRDN   = 2'h2,
        MODE_RESET   = 2'h3
    } octd_mode_t;

    // Load-strobe options
    localparam logic [1:0] LOAD_TRANSP = 2'h0;
    localparam logic [1:0] LOAD_LATCH  = 2'h1;
    localparam logic [1:0] LOAD_SINGLE = 2'h2;

    // Reference setup; packed order matches word bits 5..0
    typedef struct packed {
        logic [1:0] gain;
        logic [1:0] ref_buf;
        logic [1:0] vdd;
    } octd_refcfg_t;

    // Serial pins as sampled from outside the clock domain
    typedef struct packed {
        logic load_n;
        logic sdin;
        logic sclk;
        logic strobe_n;
    } octd_pins_t;

    // Power-on values
    localparam octd_refcfg_t REFCFG_RST = 6'h00;
    localparam logic [7:0]   PD_RST     = 8'h00;
    localparam octd_pins_t   PINS_RST   = 4'h9;

    // APB map (byte addresses)
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_STATUS  = 8'h04;
    localparam logic [7:0]  OFF_WORDS   = 8'h08;
    localparam logic [7:0]  OFF_LAST    = 8'h0c;
    localparam logic [2:0]  BANK_INPUT  = 3'h1;
    localparam logic [2:0]  BANK_OUTPUT = 3'h2;
    localparam int          CTRL_LINK_EN = 0;
    localparam int          CTRL_SW_LOAD = 1;
    localparam logic        LINK_EN_RST  = 1'b1;

endpackage

/* hdl/octd_serial_decoder.sv */
// Serial command decoder of an eight-channel converter with an APB register window
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module octd_serial_decoder
    import octd_pkg::*;
#(
    parameter int DAC_BITS = 12
)
(
    // Clock and reset
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [ADDR_W-1:0]            paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Serial pins
    input  wire logic                         frame_n,
    input  wire logic                         sclk,
    input  wire logic                         sdin,
    input  wire logic                         output_load_n,
    // Converter side
    output logic      [NUM_CH*DAC_BITS-1:0]   dac_code,
    output logic      [NUM_CH-1:0]            chan_out_en,
    output octd_refcfg_t                      ref_cfg
);

    // Only the three documented resolutions are served
    if (DAC_BITS != 8 && DAC_BITS != 10 && DAC_BITS != 12)
    begin : g_bad_width
        $error("DAC_BITS must be 8, 10 or 12");
    end

    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} octd_state_t;

    // Pin synchronisers: stage one is read only by stage two
    octd_pins_t pin_meta_r;
    octd_pins_t pin_sync_r;
    logic       sclk_d_r;
    logic       strobe_d_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_meta_r <= PINS_RST;
            pin_sync_r <= PINS_RST;
            sclk_d_r   <= PINS_RST.sclk;
            strobe_d_r <= PINS_RST.strobe_n;
        end
        else
        begin
            pin_meta_r <= '{load_n: output_load_n, sdin: sdin, sclk: sclk, strobe_n: frame_n};
            pin_sync_r <= pin_meta_r;
            sclk_d_r   <= pin_sync_r.sclk;
            strobe_d_r <= pin_sync_r.strobe_n;
        end
    end

    // Edge detection on the synchronised pins
    logic link_en_r;
    wire  sclk_fall   = sclk_d_r & ~pin_sync_r.sclk;
    wire  strobe_fall = strobe_d_r & ~pin_sync_r.strobe_n;
    wire  strobe_rise = ~strobe_d_r & pin_sync_r.strobe_n;

    // Frame state and bit counter
    octd_state_t            state_r;
    octd_state_t            state_nxt;
    logic [CNT_W-1:0]       bit_cnt_r;
    logic [WORD_BITS-1:0]   shift_r;
    logic                   cmd_valid_r;
    logic [WORD_BITS-1:0]   cmd_r;
    logic [15:0]            words_ok_r;
    logic [15:0]            words_abort_r;

    wire take_bit   = (state_r == ST_SHIFT) && sclk_fall && (bit_cnt_r < FULL_COUNT);
    wire frame_done = (state_r == ST_SHIFT) && strobe_rise;
    wire frame_full = frame_done && (bit_cnt_r == FULL_COUNT);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (strobe_fall && link_en_r) state_nxt = ST_SHIFT;
            ST_SHIFT: if (strobe_rise) state_nxt = ST_IDLE;
        endcase
    end

    // Shift in MSB first; clock edges past sixteen are ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= '0;
            shift_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE)
                bit_cnt_r <= '0;
            else if (take_bit)
                bit_cnt_r <= bit_cnt_r + 5'h01;
            if (take_bit)
                shift_r <= {shift_r[WORD_BITS-2:0], pin_sync_r.sdin};
        end
    end

    // A word is released only on a full frame; short frames count as aborts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_valid_r   <= 1'b0;
            cmd_r         <= '0;
            words_ok_r    <= '0;
            words_abort_r <= '0;
        end
        else
        begin
            cmd_valid_r <= frame_full;
            if (frame_full)
            begin
                cmd_r      <= shift_r;
                words_ok_r <= words_ok_r + 16'h0001;
            end
            if (frame_done && !frame_full)
                words_abort_r <= words_abort_r + 16'h0001;
        end
    end

    // Command decode
    octd_mode_t      cmd_mode;
    wire             cmd_is_ctrl = cmd_r[BIT_DC];
    wire [CH_W-1:0]  cmd_ch      = cmd_r[BIT_CH_HI:BIT_CH_LO];
    wire [DAC_BITS-1:0] cmd_data = cmd_r[BIT_DATA_HI -: DAC_BITS];
    wire [1:0]       cmd_opt     = cmd_r[BIT_LOAD_HI:0];
    assign cmd_mode = octd_mode_t'(cmd_r[BIT_MODE_HI:BIT_MODE_LO]);

    wire do_data  = cmd_valid_r && !cmd_is_ctrl;
    wire do_ref   = cmd_valid_r && cmd_is_ctrl && (cmd_mode == MODE_REFGAIN);
    wire do_load  = cmd_valid_r && cmd_is_ctrl && (cmd_mode == MODE_LOAD);
    wire do_pd    = cmd_valid_r && cmd_is_ctrl && (cmd_mode == MODE_PWRDN);
    wire do_rst   = cmd_valid_r && cmd_is_ctrl && (cmd_mode == MODE_RESET);
    wire do_rst_all = do_rst && cmd_r[BIT_RST_ALL];
    wire opt_store  = do_load && (cmd_opt == LOAD_TRANSP || cmd_opt == LOAD_LATCH);
    wire opt_single = do_load && (cmd_opt == LOAD_SINGLE);

    // Control settings; reserved load option leaves everything alone
    octd_refcfg_t ref_r;
    logic [1:0]   load_opt_r;
    logic [7:0]   pd_r;
    logic         single_r;
    logic         sw_load_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_r      <= REFCFG_RST;
            load_opt_r <= LOAD_LATCH;
            pd_r       <= PD_RST;
            single_r   <= 1'b0;
        end
        else
        begin
            single_r <= opt_single;
            if (do_rst_all)
            begin
                ref_r      <= REFCFG_RST;
                load_opt_r <= LOAD_LATCH;
                pd_r       <= PD_RST;
            end
            if (do_ref)
                ref_r <= octd_refcfg_t'(cmd_r[BIT_REF_HI:0]);
            if (opt_store)
                load_opt_r <= cmd_opt;
            if (do_pd)
                pd_r <= cmd_r[BIT_PD_HI:0];
        end
    end

    // Output registers follow inputs when transparent, on the pin, on a single update, or on a software load
    wire load_now = (load_opt_r == LOAD_TRANSP) || !pin_sync_r.load_n || single_r || sw_load_r;

    logic [DAC_BITS-1:0] in_r  [NUM_CH];
    logic [DAC_BITS-1:0] out_r [NUM_CH];
    logic [NUM_CH-1:0]   fresh_r;

    // Per channel: an output only reloads if its input was written since the last load, which avoids needless updates
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_chan
        wire wr_here = do_data && (cmd_ch == CH_W'(i));
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                in_r[i]    <= '0;
                out_r[i]   <= '0;
                fresh_r[i] <= 1'b0;
            end
            else if (do_rst)
            begin
                in_r[i]    <= '0;
                out_r[i]   <= '0;
                fresh_r[i] <= 1'b0;
            end
            else
            begin
                if (wr_here)
                    in_r[i] <= cmd_data;
                if (load_now && fresh_r[i])
                    out_r[i] <= in_r[i];
                fresh_r[i] <= wr_here || (fresh_r[i] && !load_now);
            end
        end
        assign dac_code[i*DAC_BITS +: DAC_BITS] = out_r[i];
    end

    // Supply reference overrides buffering and gain of its group
    octd_refcfg_t ref_eff;
    assign ref_eff.vdd     = ref_r.vdd;
    assign ref_eff.ref_buf = ref_r.ref_buf & ~ref_r.vdd;
    assign ref_eff.gain    = ref_r.gain & ~ref_r.vdd;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_cfg     <= REFCFG_RST;
            chan_out_en <= ~PD_RST;
        end
        else
        begin
            ref_cfg     <= ref_eff;
            chan_out_en <= ~pd_r;
        end
    end

    // APB decode: zero wait states, answer prepared in the setup cycle
    wire       setup    = psel && !penable;
    wire       acc_wr   = psel && penable && pready && pwrite;
    wire       aligned  = (paddr[1:0] == 2'h0);
    wire       hit_ctrl = (paddr == OFF_CTRL);
    wire       hit_stat = (paddr == OFF_STATUS);
    wire       hit_word = (paddr == OFF_WORDS);
    wire       hit_last = (paddr == OFF_LAST);
    wire       hit_in   = aligned && (paddr[7:5] == BANK_INPUT);
    wire       hit_out  = aligned && (paddr[7:5] == BANK_OUTPUT);
    wire [2:0] rd_ch    = paddr[4:2];
    wire       hit_any  = hit_ctrl | hit_stat | hit_word | hit_last | hit_in | hit_out;

    wire [31:0] rd_status = {7'h00, state_r == ST_SHIFT, 3'h0, bit_cnt_r,
                             ref_r.gain, ref_r.ref_buf, ref_r.vdd, load_opt_r, pd_r};
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, 1'b0, link_en_r} :
        hit_stat ? rd_status :
        hit_word ? {words_abort_r, words_ok_r} :
        hit_last ? {16'h0000, cmd_r} :
        hit_in   ? 32'(in_r[rd_ch]) :
        hit_out  ? 32'(out_r[rd_ch]) : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !hit_any;
            prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software control; the load bit is a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_en_r <= LINK_EN_RST;
            sw_load_r <= 1'b0;
        end
        else
        begin
            sw_load_r <= acc_wr && hit_ctrl && pwdata[CTRL_SW_LOAD];
            if (acc_wr && hit_ctrl)
                link_en_r <= pwdata[CTRL_LINK_EN];
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_bound: assert property (bit_cnt_r <= FULL_COUNT)
        else $error("bit count beyond word length");
    a_shift_step: assert property (take_bit |=> bit_cnt_r == $past(bit_cnt_r) + 5'h01)
        else $error("falling edge not counted");
    a_idle_frozen: assert property ($changed(shift_r) |-> $past(take_bit))
        else $error("shift outside active frame");
    a_abort_drop: assert property (frame_done && !frame_full |=> !cmd_valid_r ##1 !do_data)
        else $error("short frame decoded");
    a_full_decode: assert property (frame_full |=> cmd_valid_r && cmd_r == $past(shift_r))
        else $error("full frame not decoded");
    a_data_lands: assert property (do_data && !do_rst
        |=> in_r[$past(cmd_ch)] == $past(cmd_data))
        else $error("channel data not stored");
    a_vdd_forces: assert property (ref_cfg.vdd[0]
        |-> !ref_cfg.ref_buf[0] && !ref_cfg.gain[0])
        else $error("supply reference not forcing group");
    a_vdd_forces_eh: assert property (ref_cfg.vdd[1]
        |-> !ref_cfg.ref_buf[1] && !ref_cfg.gain[1])
        else $error("supply reference not forcing upper group");
    a_pd_tristate: assert property (do_pd |=> ##1 chan_out_en == ~$past(cmd_r[7:0], 2))
        else $error("power-down mask not applied");
    a_reset_clears: assert property (do_rst |=> in_r[0] == '0 && out_r[7] == '0)
        else $error("data reset left values");
    a_opt_store: assert property (opt_store |=> load_opt_r == $past(cmd_opt))
        else $error("load option not stored");
    // A reserved option must never touch the stored option
    a_rsv_ignored: assert property (do_load && !opt_store && !opt_single
        |=> load_opt_r == $past(load_opt_r))
        else $error("reserved load option stored");
    a_single_pulse: assert property (opt_single |=> single_r ##1 !single_r)
        else $error("single update not one pulse");
    // Power-down only gates the outputs; data and settings stay put
    a_pd_keeps: assert property (do_pd
        |=> in_r[0] == $past(in_r[0]) && ref_r == $past(ref_r))
        else $error("power-down altered registers");
    a_full_rst_cfg: assert property (do_rst_all
        |=> ref_r == REFCFG_RST && load_opt_r == LOAD_LATCH && pd_r == PD_RST)
        else $error("control reset left settings");
    // A disabled link must not open a frame, whatever the strobe does
    a_link_off: assert property (state_r == ST_IDLE && !link_en_r
        |=> state_r == ST_IDLE)
        else $error("frame opened while link disabled");

    // Main scenarios
    c_data_write: cover property (do_data);
    c_single:     cover property (opt_single);
    c_abort:      cover property (frame_done && !frame_full);
    c_power_down: cover property (do_pd ##2 chan_out_en != 8'hff);
    c_full_reset: cover property (do_rst_all);

endmodule

/* tb/octd_host_model.sv */
// Host serial port model that frames and shifts command words into the decoder
`timescale 1ns/1ps
module octd_host_model
(
    // Serial pins driven towards the device
    output logic frame_n,
    output logic sclk,
    output logic sdin
);
    // Idle: strobe high, clock parked high, data line high
    initial
    begin
        frame_n = 1'b1;
        sclk    = 1'b1;
        sdin    = 1'b1;
    end

    // Send the top n bits of w; n below 16 leaves a partial frame
    // Delays keep the link clock out of phase with the bus clock
    task automatic send(input logic [15:0] w, input int n);
        int i;
        #13;
        frame_n = 1'b0;
        #200;
        for (i = 15; i > 15 - n; i--)
        begin
            sdin = w[i];
            #100;
            sclk = 1'b0;
            #200;
            sclk = 1'b1;
            #100;
        end
        #100;
        frame_n = 1'b1;
        sdin    = ~sdin; // Released line must not keep the last bit
        #400;
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the octal converter serial decoder
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    import octd_pkg::*;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                frame_n;
    logic                sclk;
    logic                sdin;
    logic                output_load_n = 1'b1;
    logic [8*12-1:0]     dac_code;
    logic [7:0]          chan_out_en;
    octd_refcfg_t        ref_cfg;
    int                  n_errors = 0;
    int                  checked = 0;
    logic [31:0]         rd;
    logic                er;

    // 50 ns bus clock
    always #25 pclk = ~pclk;

    octd_serial_decoder #(.DAC_BITS(12)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_n(frame_n), .sclk(sclk),
        .sdin(sdin), .output_load_n(output_load_n), .dac_code(dac_code),
        .chan_out_en(chan_out_en), .ref_cfg(ref_cfg));

    octd_host_model host (.frame_n(frame_n), .sclk(sclk), .sdin(sdin));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_errors++;
            wrap_up();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Codes fill all twelve data bits; a narrower part wants its dropped bits zero
    function automatic logic [11:0] code_of(input int ch);
        return 12'hfff - 12'(ch) * 12'h123;
    endfunction

    function automatic logic [11:0] dac(input int ch);
        return dac_code[ch*12 +: 12];
    endfunction

    // Power-on state and refused access
    task automatic t_reset();
        `CHK("dac_code", 96'h0, dac_code)
        `CHK("chan_out_en", 8'hff, chan_out_en)
        `CHK("ref_cfg", 6'h00, ref_cfg)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("load opt", 2'h1, rd[9:8])
        `CHK("mapped err", 1'b0, er)
        apb(1'b0, 8'h80, 32'h0);
        `CHK("unmapped err", 1'b1, er)
        `CHK("unmapped data", 32'h0, rd)
        $display("test reset done");
    endtask

    // Transparent mode, every channel address decoded
    task automatic t_data();
        int ch;
        host.send(16'ha000, 16);
        for (ch = 0; ch < 8; ch++)
            host.send({1'b0, 3'(ch), code_of(ch)}, 16);
        for (ch = 0; ch < 8; ch++)
        begin
            `CHK("dac ch", code_of(ch), dac(ch))
            apb(1'b0, 8'h20 + 8'(4 * ch), 32'h0);
            `CHK("input reg", code_of(ch), rd[11:0])
        end
        $display("test data done");
    endtask

    // Latched, pin load and single update
    task automatic t_latch();
        host.send(16'ha001, 16);
        host.send(16'h25a5, 16);
        `CHK("latched", code_of(2), dac(2))
        @(posedge pclk) output_load_n <= 1'b0;
        repeat (4) @(posedge pclk);
        output_load_n <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK("pin load", 12'h5a5, dac(2))
        host.send(16'h33c3, 16);
        host.send(16'ha002, 16);
        `CHK("single", 12'h3c3, dac(3))
        host.send(16'h3111, 16);
        `CHK("after single", 12'h3c3, dac(3))
        host.send(16'ha003, 16);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("opt kept", 2'h1, rd[9:8])
        $display("test latch done");
    endtask

    // Partial frame is discarded
    task automatic t_abort();
        host.send(16'h1abc, 10);
        host.send(16'h1abc, 15);
        apb(1'b0, 8'h24, 32'h0);
        `CHK("abort input", code_of(1), rd[11:0])
        apb(1'b0, OFF_WORDS, 32'h0);
        `CHK("aborts", 16'h2, rd[31:16])
        `CHK("words", 16'h0f, rd[15:0])
        $display("test abort done");
    endtask

    // Reference, gain and supply precedence
    task automatic t_refgain();
        host.send(16'h803e, 16);
        `CHK("ref_cfg", 6'h16, ref_cfg)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("stored", 6'h3e, rd[15:10])
        host.send(16'h8035, 16);
        `CHK("ref_cfg", 6'h21, ref_cfg)
        $display("test refgain done");
    endtask

    // Power-down keeps loading data
    task automatic t_pwrdn();
        host.send(16'ha000, 16);
        host.send(16'hc0a5, 16);
        `CHK("out en", 8'h5a, chan_out_en)
        host.send(16'h0123, 16);
        `CHK("pd load", 12'h123, dac(0))
        host.send(16'hc000, 16);
        `CHK("out en", 8'hff, chan_out_en)
        `CHK("resume", 12'h123, dac(0))
        $display("test pwrdn done");
    endtask

    // Data reset then full reset
    task automatic t_resets();
        host.send(16'hc00f, 16);
        host.send(16'hefff, 16);
        `CHK("data rst", 96'h0, dac_code)
        `CHK("pd kept", 8'hf0, chan_out_en)
        `CHK("cfg kept", 6'h21, ref_cfg)
        host.send(16'hf000, 16);
        `CHK("full rst", 8'hff, chan_out_en)
        `CHK("full cfg", 6'h00, ref_cfg)
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("opt rst", 2'h1, rd[9:8])
        $display("test resets done");
    endtask

    // Link disabled ignores frames
    task automatic t_link();
        apb(1'b1, OFF_CTRL, 32'h0);
        host.send(16'h1abc, 16);
        apb(1'b0, 8'h24, 32'h0);
        `CHK("link off", 12'h000, rd[11:0])
        apb(1'b1, OFF_CTRL, 32'h1);
        host.send(16'h1abc, 16);
        apb(1'b0, 8'h24, 32'h0);
        `CHK("link on", 12'habc, rd[11:0])
        `CHK("latched out", 12'h000, dac(1))
        apb(1'b1, OFF_CTRL, 32'h3);
        apb(1'b0, 8'h44, 32'h0);
        `CHK("sw load reg", 12'habc, rd[11:0])
        `CHK("sw load out", 12'habc, dac(1))
        apb(1'b0, OFF_LAST, 32'h0);
        `CHK("last word", 32'h0000_1abc, rd)
        $display("test link done");
    endtask

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_data();
        t_latch();
        t_abort();
        t_refgain();
        t_pwrdn();
        t_resets();
        t_link();
        wrap_up();
    end
endmodule
